// *** hw/ssq_regs.svh ***
// Contract
// - Power-up turns enables on one at a time
// - Each new rail must rise before blanking ends
// - Good rail moves on to the next enable
// - Sequence delay precedes every power-up enable
// - Completion output goes high after full power-up
// - Power-down turns enables off in reverse order
// - Power-down reuses each step's sequence delay
// - No blanking or rail check during power-down
// - Completion output low after last enable off
// - Faults watched while sequencing and when powered
// - Faults: rail undervoltage or unexpected control change
// - Fault drops every enable at once, no delays
// - Fault handling ends ready for fresh power-up
// - Own fault pulls the shared fault line low
// - Peer pulling fault line low forces fault handling
`ifndef SSQ_REGS_SVH
`define SSQ_REGS_SVH

// Clock period of mclk
`define SSQ_CLK_PERIOD_NS 10

// Least glitch times and fault hold time, rounded up to whole clock cycles
`define SSQ_RAIL_RISE_NS 19900
`define SSQ_RAIL_FALL_NS 2750
`define SSQ_CTRL_GLITCH_NS 3300
`define SSQ_FAULT_GLITCH_NS 3100
`define SSQ_FAULT_HOLD_NS 10000

`define SSQ_RAIL_RISE_CYC \
    ((`SSQ_RAIL_RISE_NS + `SSQ_CLK_PERIOD_NS - 1) / `SSQ_CLK_PERIOD_NS)
`define SSQ_RAIL_FALL_CYC \
    ((`SSQ_RAIL_FALL_NS + `SSQ_CLK_PERIOD_NS - 1) / `SSQ_CLK_PERIOD_NS)
`define SSQ_CTRL_GLITCH_CYC \
    ((`SSQ_CTRL_GLITCH_NS + `SSQ_CLK_PERIOD_NS - 1) / `SSQ_CLK_PERIOD_NS)
`define SSQ_FAULT_GLITCH_CYC \
    ((`SSQ_FAULT_GLITCH_NS + `SSQ_CLK_PERIOD_NS - 1) / `SSQ_CLK_PERIOD_NS)
`define SSQ_FAULT_HOLD_CYC \
    ((`SSQ_FAULT_HOLD_NS + `SSQ_CLK_PERIOD_NS - 1) / `SSQ_CLK_PERIOD_NS)

// Reset values of the pin-facing flops
`define SSQ_RST_ENABLE 1'b0
`define SSQ_RST_DONE 1'b0
`define SSQ_RST_FAULT_OE 1'b0

`endif

// *** hw/ssq_pkg.sv ***
package ssq_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ssq_st_idle,
        ssq_st_up_delay,
        ssq_st_up_blank,
        ssq_st_up_done,
        ssq_st_dn_delay,
        ssq_st_fault_hold,
        ssq_st_fault_wait
    } ssq_state_type;

endpackage

// *** hw/ssq_timer.sv ***
`timescale 1ns/1ps
// Down counter that pulses once when a loaded delay has run out
module ssq_timer #(
    parameter int DW = 24
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [DW-1:0] load_value,
    output logic done_pulse
);
    logic [DW-1:0] cnt_q; // Remaining cycles
    logic run_q; // Delay in progress
    logic done_q; // One-cycle expiry pulse

    // Count down after a load; a new load restarts the delay
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else if (load) begin
            cnt_q <= load_value;
            run_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            done_q <= run_q && (cnt_q == '0);
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - DW'(1);
            end else begin
                run_q <= 1'b0;
            end
        end
    end

    assign done_pulse = done_q;
endmodule // ssq_timer

// *** hw/ssq_filter.sv ***
`timescale 1ns/1ps
// Glitch filter: output follows input only after it held steady
module ssq_filter #(
    parameter int RISE_CYC = 330,
    parameter int FALL_CYC = 330,
    parameter logic INIT_LEVEL = 1'b0,
    parameter int CW = 12
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic raw_in,
    output logic filt_out
);
    localparam logic [CW-1:0] RISE_LIM = CW'(RISE_CYC - 1);
    localparam logic [CW-1:0] FALL_LIM = CW'(FALL_CYC - 1);

    logic [CW-1:0] cnt_q; // Cycles the input has differed
    logic level_q; // Filtered level
    logic differs; // Input differs from filtered level
    logic [CW-1:0] limit; // Hold time for the pending edge

    assign differs = raw_in != level_q;
    assign limit = raw_in ? RISE_LIM : FALL_LIM;

    // Flip the level once the new value has held long enough
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= '0;
            level_q <= INIT_LEVEL;
        end else if (!differs) begin
            cnt_q <= '0;
        end else if (cnt_q >= limit) begin
            cnt_q <= '0;
            level_q <= raw_in;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign filt_out = level_q;
endmodule // ssq_filter

// *** hw/ssq_sequencer.sv ***
`timescale 1ns/1ps
`include "ssq_regs.svh"
// Supply sequencer: ordered power-up with blanking checks, reverse
// power-down, and a shared open-drain fault line for cascading.
module ssq_sequencer #(
    parameter int N_RAILS = 4,
    parameter int DW = 24,
    parameter int RAIL_RISE_CYC = `SSQ_RAIL_RISE_CYC,
    parameter int RAIL_FALL_CYC = `SSQ_RAIL_FALL_CYC,
    parameter int CTRL_GLITCH_CYC = `SSQ_CTRL_GLITCH_CYC,
    parameter int FAULT_GLITCH_CYC = `SSQ_FAULT_GLITCH_CYC,
    parameter int FAULT_HOLD_CYC = `SSQ_FAULT_HOLD_CYC
) (
    // Clock and synchronous reset
    input wire logic mclk,
    input wire logic rst,
    // Direction control: high asks for power-up, low for power-down
    input wire logic power_up_request,
    // High when the rail sits above its undervoltage threshold
    input wire logic [N_RAILS-1:0] monitored_rail_input,
    // Per-step sequence delays in cycles, step 0 in the low bits
    input wire logic [N_RAILS*DW-1:0] step_delay_cycles,
    // Blanking interval in cycles
    input wire logic [DW-1:0] blank_cycles,
    // Supply enables, bit 0 first on
    output logic [N_RAILS-1:0] supply_enable,
    // Completion level and its pull-low enable
    output logic sequence_complete_out,
    output logic sequence_complete_oe,
    // Shared fault line: wire level in, drive value and enable out
    input wire logic fault_line_in,
    output logic fault_line_out,
    output logic fault_line_oe,
    // High while fault handling runs
    output logic fault_active
);
    localparam int SW = $clog2(N_RAILS + 1);
    localparam logic [SW-1:0] STEP_ONE = SW'(1);
    localparam logic [SW-1:0] STEP_LAST = SW'(N_RAILS);
    localparam logic [DW-1:0] HOLD_CYC = DW'(FAULT_HOLD_CYC);

    // Thermometer mask: lowest n enables on
    function automatic logic [N_RAILS-1:0] therm(input logic [SW-1:0] n);
        logic [N_RAILS-1:0] m;
        m = '0;
        for (int i = 0; i < N_RAILS; i++) begin
            m[i] = (i < int'(n));
        end
        return m;
    endfunction

    // Sequence delay of a given step
    function automatic logic [DW-1:0] sel_delay(input logic [SW-1:0] idx);
        logic [DW-1:0] v;
        v = step_delay_cycles[int'(idx)*DW +: DW];
        return v;
    endfunction

    // Registered state
    ssq_pkg::ssq_state_type state_q; // Current state
    ssq_pkg::ssq_state_type state_d; // Next state
    logic [SW-1:0] step_q; // Number of enables on
    logic [SW-1:0] step_d; // Next enable count
    logic dir_prev_q; // Filtered direction of the last cycle
    logic [N_RAILS-1:0] enable_q; // Enable pins
    logic done_q; // Completion level
    logic done_oe_q; // Completion pull-low
    logic fault_oe_q; // Fault line pull-low
    logic fault_out_q; // Fault line drive value
    logic fault_act_q; // Fault handling flag

    // Filtered inputs
    logic dir_f; // Direction after glitch filter
    logic line_f; // Fault line after glitch filter, high when released
    logic [N_RAILS-1:0] rail_f; // Rails after glitch filter

    // Timer control
    logic tmr_load; // Start a delay
    logic [DW-1:0] tmr_value; // Delay to start
    logic tmr_done; // Delay ran out

    // Decoded conditions
    logic [SW-1:0] step_inc; // Step after one more enable
    logic [SW-1:0] step_dec; // Step after one less enable
    logic [SW-1:0] step_dec2; // Two less, next power-down step
    logic dir_change; // Direction moved this cycle
    logic in_up; // Power-up stepping
    logic in_rest_up; // Fully powered
    logic in_fault; // Fault handling states
    logic [N_RAILS-1:0] check_mask; // Rails that must be good now
    logic uv_fault; // Undervoltage on a checked rail
    logic cur_rail_ok; // Newest enabled rail is good
    logic blank_timeout; // Blanking ran out with rail still low
    logic ctrl_fault; // Unexpected direction change
    logic peer_fault; // Another party pulls the fault line
    logic any_fault; // Any reason to enter fault handling

    // Direction filter
    ssq_filter #(
        .RISE_CYC(CTRL_GLITCH_CYC),
        .FALL_CYC(CTRL_GLITCH_CYC),
        .INIT_LEVEL(1'b0)
    ) u_dir_filter (
        .mclk(mclk),
        .rst(rst),
        .raw_in(power_up_request),
        .filt_out(dir_f)
    );

    // Fault line filter, idles released
    ssq_filter #(
        .RISE_CYC(FAULT_GLITCH_CYC),
        .FALL_CYC(FAULT_GLITCH_CYC),
        .INIT_LEVEL(1'b1)
    ) u_line_filter (
        .mclk(mclk),
        .rst(rst),
        .raw_in(fault_line_in),
        .filt_out(line_f)
    );

    // One filter per monitored rail
    for (genvar g = 0; g < N_RAILS; g++) begin : g_rail
        ssq_filter #(
            .RISE_CYC(RAIL_RISE_CYC),
            .FALL_CYC(RAIL_FALL_CYC),
            .INIT_LEVEL(1'b0)
        ) u_rail_filter (
            .mclk(mclk),
            .rst(rst),
            .raw_in(monitored_rail_input[g]),
            .filt_out(rail_f[g])
        );
    end

    // Shared timer for sequence, blanking and fault hold delays
    ssq_timer #(
        .DW(DW)
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .load(tmr_load),
        .load_value(tmr_value),
        .done_pulse(tmr_done)
    );

    // Step arithmetic
    assign step_inc = step_q + STEP_ONE;
    assign step_dec = step_q - STEP_ONE;
    assign step_dec2 = step_dec - STEP_ONE;

    // State decode
    assign in_up = (state_q == ssq_pkg::ssq_st_up_delay) ||
                   (state_q == ssq_pkg::ssq_st_up_blank);
    assign in_rest_up = state_q == ssq_pkg::ssq_st_up_done;
    assign in_fault = (state_q == ssq_pkg::ssq_st_fault_hold) ||
                      (state_q == ssq_pkg::ssq_st_fault_wait);
    assign dir_change = dir_f != dir_prev_q;

    // Rails proven good; the newest one is exempt while blanking
    assign check_mask = (state_q == ssq_pkg::ssq_st_up_blank) ?
                        therm(step_dec) : therm(step_q);
    // Only power-up and rest check rails, never power-down
    assign uv_fault = (in_up || in_rest_up) &&
                      (|(check_mask & ~rail_f));
    assign cur_rail_ok = rail_f[int'(step_dec)];
    assign blank_timeout = (state_q == ssq_pkg::ssq_st_up_blank) &&
                           tmr_done && !cur_rail_ok;
    // Direction may only move while idle, fully powered or in fault handling
    assign ctrl_fault = dir_change && (in_up ||
                        (state_q == ssq_pkg::ssq_st_dn_delay));
    // Line low from a peer; we never drive it outside fault handling
    assign peer_fault = !line_f && !in_fault;
    assign any_fault = uv_fault || blank_timeout || ctrl_fault ||
                       peer_fault;

    // Next state, step count and timer loads
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        tmr_load = 1'b0;
        tmr_value = '0;
        unique case (state_q)
            ssq_pkg::ssq_st_idle: begin
                if (peer_fault) begin
                    state_d = ssq_pkg::ssq_st_fault_hold;
                end else if (dir_f) begin
                    // First sequence delay before the first enable
                    state_d = ssq_pkg::ssq_st_up_delay;
                    tmr_load = 1'b1;
                    tmr_value = sel_delay('0);
                end
            end
            ssq_pkg::ssq_st_up_delay: begin
                if (any_fault) begin
                    state_d = ssq_pkg::ssq_st_fault_hold;
                end else if (tmr_done) begin
                    // Turn on only the next enable, then blank
                    step_d = step_inc;
                    state_d = ssq_pkg::ssq_st_up_blank;
                    tmr_load = 1'b1;
                    tmr_value = blank_cycles;
                end
            end
            ssq_pkg::ssq_st_up_blank: begin
                if (any_fault) begin
                    state_d = ssq_pkg::ssq_st_fault_hold;
                end else if (cur_rail_ok) begin
                    if (step_q == STEP_LAST) begin
                        state_d = ssq_pkg::ssq_st_up_done;
                    end else begin
                        // Next step starts with its own delay
                        state_d = ssq_pkg::ssq_st_up_delay;
                        tmr_load = 1'b1;
                        tmr_value = sel_delay(step_q);
                    end
                end
            end
            ssq_pkg::ssq_st_up_done: begin
                if (any_fault) begin
                    state_d = ssq_pkg::ssq_st_fault_hold;
                end else if (!dir_f) begin
                    // Power-down starts with the last step's delay
                    state_d = ssq_pkg::ssq_st_dn_delay;
                    tmr_load = 1'b1;
                    tmr_value = sel_delay(step_dec);
                end
            end
            ssq_pkg::ssq_st_dn_delay: begin
                if (any_fault) begin
                    state_d = ssq_pkg::ssq_st_fault_hold;
                end else if (tmr_done) begin
                    // Drop the highest enable still on
                    step_d = step_dec;
                    if (step_q == STEP_ONE) begin
                        state_d = ssq_pkg::ssq_st_idle;
                    end else begin
                        tmr_load = 1'b1;
                        tmr_value = sel_delay(step_dec2);
                    end
                end
            end
            ssq_pkg::ssq_st_fault_hold: begin
                // Hold the fault line low for a minimum time
                if (tmr_done) begin
                    state_d = ssq_pkg::ssq_st_fault_wait;
                end
            end
            ssq_pkg::ssq_st_fault_wait: begin
                // Leave once the line is free and power-up is withdrawn
                if (line_f && !dir_f) begin
                    state_d = ssq_pkg::ssq_st_idle;
                end
            end
        endcase
        // Every fault entry clears all enables and starts the hold
        if (!in_fault && state_d == ssq_pkg::ssq_st_fault_hold) begin
            step_d = '0;
            tmr_load = 1'b1;
            tmr_value = HOLD_CYC;
        end
    end

    // State, step and direction history
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ssq_pkg::ssq_st_idle;
            step_q <= '0;
            dir_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            dir_prev_q <= dir_f;
        end
    end

    // Enable pins follow the next step count, so a fault drops all
    always_ff @(posedge mclk) begin
        if (rst) begin
            enable_q <= {N_RAILS{`SSQ_RST_ENABLE}};
        end else begin
            enable_q <= therm(step_d);
        end
    end

    // Completion high from full power-up until the last enable drops
    always_ff @(posedge mclk) begin
        if (rst) begin
            done_q <= `SSQ_RST_DONE;
            done_oe_q <= !`SSQ_RST_DONE;
        end else begin
            done_q <= (state_d == ssq_pkg::ssq_st_up_done) ||
                      (state_d == ssq_pkg::ssq_st_dn_delay);
            done_oe_q <= !((state_d == ssq_pkg::ssq_st_up_done) ||
                           (state_d == ssq_pkg::ssq_st_dn_delay));
        end
    end

    // Fault line pulled low while the hold runs
    always_ff @(posedge mclk) begin
        if (rst) begin
            fault_oe_q <= `SSQ_RST_FAULT_OE;
            fault_out_q <= 1'b0;
            fault_act_q <= 1'b0;
        end else begin
            fault_oe_q <= state_d == ssq_pkg::ssq_st_fault_hold;
            fault_out_q <= 1'b0;
            fault_act_q <= (state_d == ssq_pkg::ssq_st_fault_hold) ||
                           (state_d == ssq_pkg::ssq_st_fault_wait);
        end
    end

    // Outputs straight from flops
    assign supply_enable = enable_q;
    assign sequence_complete_out = done_q;
    assign sequence_complete_oe = done_oe_q;
    assign fault_line_out = fault_out_q;
    assign fault_line_oe = fault_oe_q;
    assign fault_active = fault_act_q;
endmodule // ssq_sequencer

// *** tb/ssq_sequencer_props.sv ***
`timescale 1ns/1ps
// Port-level checker for the supply sequencer
module ssq_sequencer_props #(
    parameter int N_RAILS = 4,
    parameter int DW = 24
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic power_up_request,
    input wire logic [N_RAILS-1:0] monitored_rail_input,
    input wire logic [N_RAILS*DW-1:0] step_delay_cycles,
    input wire logic [DW-1:0] blank_cycles,
    input wire logic [N_RAILS-1:0] supply_enable,
    input wire logic sequence_complete_out,
    input wire logic sequence_complete_oe,
    input wire logic fault_line_in,
    input wire logic fault_line_out,
    input wire logic fault_line_oe,
    input wire logic fault_active
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // All enables on
    localparam logic [N_RAILS-1:0] ALL_ON = {N_RAILS{1'b1}};

    a_enable_fill: assert property (
        (supply_enable & (supply_enable + 1'b1)) == '0)
        else $error("enables not filled from bit 0");
    a_up_one_step: assert property (
        (!$past(rst) && supply_enable > $past(supply_enable))
        |-> supply_enable == N_RAILS'({$past(supply_enable), 1'b1}))
        else $error("power-up added more than one enable");
    a_down_reverse: assert property (
        (!$past(rst) && supply_enable < $past(supply_enable) && !fault_active)
        |-> supply_enable == ($past(supply_enable) >> 1))
        else $error("power-down did not drop the top enable only");
    a_fault_drops_all: assert property (
        $rose(fault_active) |-> supply_enable == '0 && !sequence_complete_out)
        else $error("fault entry left an enable or completion on");
    a_line_only_fault: assert property (
        fault_line_oe |-> fault_active && !fault_line_out)
        else $error("fault line driven outside fault handling");
    a_fault_line_hold: assert property (
        $rose(fault_line_oe) |-> fault_line_oe [*5])
        else $error("fault line released too early");
    a_done_full_up: assert property (
        $rose(sequence_complete_out)
        |-> supply_enable == ALL_ON && $past(supply_enable) == ALL_ON)
        else $error("completion rose before all enables were on");
    a_done_open_drain: assert property (
        sequence_complete_oe == !sequence_complete_out)
        else $error("completion pull-low enable not inverse of level");
    a_done_fall_last: assert property (
        ($fell(sequence_complete_out) && !fault_active && !$past(rst))
        |-> supply_enable == '0 && $past(supply_enable) == N_RAILS'(1))
        else $error("completion fell not with the last enable");
    a_peer_fault_entry: assert property (
        (!fault_line_in && !fault_active) [*4] |-> ##[0:6] fault_active)
        else $error("peer fault not followed");
    a_rail_sag_fault: assert property (
        (sequence_complete_out && supply_enable == ALL_ON
            && monitored_rail_input != ALL_ON) [*4] |-> ##[0:6] fault_active)
        else $error("sagging rail in powered state missed");

    // Main scenarios reached
    c_full_up: cover property ($rose(sequence_complete_out));
    c_fault: cover property ($rose(fault_active));
    c_full_down: cover property ($fell(sequence_complete_out) && !fault_active);
endmodule // ssq_sequencer_props

bind ssq_sequencer ssq_sequencer_props #(
    .N_RAILS(N_RAILS),
    .DW(DW)
) i_ssq_sequencer_props (
    .mclk(mclk),
    .rst(rst),
    .power_up_request(power_up_request),
    .monitored_rail_input(monitored_rail_input),
    .step_delay_cycles(step_delay_cycles),
    .blank_cycles(blank_cycles),
    .supply_enable(supply_enable),
    .sequence_complete_out(sequence_complete_out),
    .sequence_complete_oe(sequence_complete_oe),
    .fault_line_in(fault_line_in),
    .fault_line_out(fault_line_out),
    .fault_line_oe(fault_line_oe),
    .fault_active(fault_active)
);

// *** tb/ssq_rail_model.sv ***
`timescale 1ns/1ps
// Regulators that ramp after their enable, plus one peer sequencer
module ssq_rail_model #(
    parameter int N_RAILS = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [N_RAILS-1:0] supply_enable,
    input wire logic [7:0] rise_cyc,
    input wire logic [N_RAILS-1:0] sag_mask,
    input wire logic peer_pull,
    output logic [N_RAILS-1:0] monitored_rail_input,
    output logic peer_oe
);
    // Ramp counters, one per rail, saturating
    logic [7:0] ramp_q [N_RAILS];

    // Ramp restarts whenever a rail is off or sagging
    always_ff @(posedge mclk) begin
        for (int k = 0; k < N_RAILS; k++) begin
            if (rst || !supply_enable[k] || sag_mask[k]) begin
                ramp_q[k] <= 8'h00;
            end else if (ramp_q[k] != 8'hFF) begin
                ramp_q[k] <= ramp_q[k] + 8'h01;
            end
        end
        // Peer pulls the shared line after its own fault
        peer_oe <= peer_pull && !rst;
    end

    // Rail reads good only once ramped; an unpowered rail reads low
    always_comb begin
        for (int k = 0; k < N_RAILS; k++) begin
            monitored_rail_input[k] = supply_enable[k] && !sag_mask[k]
                && (ramp_q[k] >= rise_cyc);
        end
    end
endmodule // ssq_rail_model

// *** tb/tb_ssq_sequencer.sv ***
`timescale 1ns/1ps
// Self-checking bench for the supply sequencer
module tb_ssq_sequencer;
    localparam int NR = 4;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic power_up_request = 1'b0;
    // Step delays 20, 60, 100, 140 cycles; blanking 60 cycles
    logic [NR*24-1:0] step_delay_cycles = {24'h8C, 24'h64, 24'h3C, 24'h14};
    logic [23:0] blank_cycles = 24'h3C;
    logic [NR-1:0] monitored_rail_input;
    logic [NR-1:0] supply_enable;
    logic sequence_complete_out, sequence_complete_oe;
    logic fault_line_in, fault_line_out, fault_line_oe, fault_active;
    logic [7:0] rise_cyc = 8'h05; // Rail ramp time
    logic [NR-1:0] sag_mask = 4'h0; // Rails forced below threshold
    logic peer_pull = 1'b0; // Peer fault request
    logic peer_oe;
    int mismatches = 0;
    int checks_done = 0;
    int gap; // Cycles spent in the last wait

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // Pulled-up shared fault line, low while anyone drives it
    assign fault_line_in = !(fault_line_oe || peer_oe);

    ssq_sequencer #(
        .RAIL_RISE_CYC(4),
        .RAIL_FALL_CYC(2),
        .CTRL_GLITCH_CYC(2),
        .FAULT_GLITCH_CYC(2),
        .FAULT_HOLD_CYC(5)
    ) i_ssq_sequencer (
        .mclk(mclk),
        .rst(rst),
        .power_up_request(power_up_request),
        .monitored_rail_input(monitored_rail_input),
        .step_delay_cycles(step_delay_cycles),
        .blank_cycles(blank_cycles),
        .supply_enable(supply_enable),
        .sequence_complete_out(sequence_complete_out),
        .sequence_complete_oe(sequence_complete_oe),
        .fault_line_in(fault_line_in),
        .fault_line_out(fault_line_out),
        .fault_line_oe(fault_line_oe),
        .fault_active(fault_active)
    );

    ssq_rail_model #(.N_RAILS(NR)) i_ssq_rail_model (
        .mclk(mclk),
        .rst(rst),
        .supply_enable(supply_enable),
        .rise_cyc(rise_cyc),
        .sag_mask(sag_mask),
        .peer_pull(peer_pull),
        .monitored_rail_input(monitored_rail_input),
        .peer_oe(peer_oe)
    );

    // Prints counts and verdict, then ends the run
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compares one value and counts it
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Delay of step k
    function automatic int dly(input int k);
        return int'(step_delay_cycles[k*24 +: 24]);
    endfunction

    // Bounded wait on {done, fault, enables} under a mask
    task automatic wait_for(input logic [NR+1:0] want,
                            input logic [NR+1:0] mask);
        gap = 0;
        while (({sequence_complete_out, fault_active, supply_enable} & mask)
               !== want) begin
            @(posedge mclk);
            #1;
            gap++;
            if (gap > 3000) begin
                check("wait target", 32'(want), 32'({sequence_complete_out,
                      fault_active, supply_enable} & mask));
                final_report();
            end
        end
    endtask

    // Full power-up with step spacing and completion
    task automatic t_up();
        @(posedge mclk);
        power_up_request <= 1'b1;
        for (int k = 0; k < NR; k++) begin
            wait_for({2'b00, NR'((1 << (k + 1)) - 1)}, 6'h0F);
            check("up gap", 32'h1,
                  32'(gap > dly(k) + 2 && gap <= dly(k) + 20));
        end
        wait_for(6'h20, 6'h20);
        check("done latency", 32'h1, 32'(gap <= 20));
        check("done pull-low", 32'h0, 32'(sequence_complete_oe));
    endtask

    // Full power-down in reverse with the same delays
    task automatic t_down();
        @(posedge mclk);
        power_up_request <= 1'b0;
        for (int k = NR - 1; k >= 0; k--) begin
            wait_for({2'b00, NR'((1 << k) - 1)}, 6'h0F);
            check("down gap", 32'h1,
                  32'(gap > dly(k) && gap <= dly(k) + 10));
            check("fault in down", 32'h0, 32'(fault_active));
            check("done in down", 32'(k != 0),
                  32'(sequence_complete_out));
        end
    endtask

    // Waits for fault entry, checks outputs, then recovers to idle
    task automatic expect_fault(input int lo, input int hi, input logic own);
        wait_for(6'h10, 6'h10);
        check("fault latency", 32'h1, 32'(gap > lo && gap <= hi));
        check("enables on fault", 32'h0, 32'(supply_enable));
        check("done on fault", 32'h0, 32'(sequence_complete_out));
        if (own) begin
            check("line pull", 32'h1, 32'(fault_line_oe));
        end
        @(posedge mclk);
        power_up_request <= 1'b0;
        sag_mask <= 4'h0;
        peer_pull <= 1'b0;
        rise_cyc <= 8'h05;
        wait_for(6'h00, 6'h10);
        check("line after fault", 32'h0, 32'(fault_line_oe));
        check("enables idle", 32'h0, 32'(supply_enable));
    endtask

    // Rail never rises: blanking runs out
    task automatic t_blank_timeout();
        @(posedge mclk);
        rise_cyc <= 8'hC8;
        power_up_request <= 1'b1;
        wait_for(6'h01, 6'h0F);
        expect_fault(60, 70, 1'b1);
    endtask

    // Direction dropped mid power-up
    task automatic t_ctrl_fault();
        @(posedge mclk);
        power_up_request <= 1'b1;
        wait_for(6'h03, 6'h0F);
        @(posedge mclk);
        power_up_request <= 1'b0;
        expect_fault(0, 12, 1'b1);
    endtask

    // Earlier rail sags while fully powered
    task automatic t_sag_fault();
        t_up();
        @(posedge mclk);
        sag_mask <= 4'h2;
        expect_fault(0, 12, 1'b1);
    endtask

    // Peer pulls the shared line while fully powered
    task automatic t_peer_fault();
        t_up();
        @(posedge mclk);
        peer_pull <= 1'b1;
        expect_fault(0, 12, 1'b0);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check("reset enables", 32'h0, 32'(supply_enable));
        check("reset done oe", 32'h1, 32'(sequence_complete_oe));
        t_up();
        t_down();
        t_blank_timeout();
        t_ctrl_fault();
        t_sag_fault();
        t_peer_fault();
        t_up();
        t_down();
        final_report();
    end
endmodule // tb_ssq_sequencer
